// file: dest_addr_consts.vh
// Constants for the destination and indirect addressing unit
`ifndef DEST_ADDR_CONSTS_VH
`define DEST_ADDR_CONSTS_VH
// Addressing mode codes
`define MODE_DST_IDX 3'h0
`define MODE_DST_DIR_IMM 3'h1
`define MODE_DST_IDX_IMM 3'h2
`define MODE_DIR_DIR 3'h3
`define MODE_SRC_IND 3'h4
`define MODE_DST_IND 3'h5
// Operation codes
`define OP_COPY 2'h0
`define OP_ADD 2'h1
`define OP_AND 2'h2
`define OP_OR 2'h3
// Instruction lengths in bytes
`define LEN_TWO 2'h2
`define LEN_THREE 2'h3
// Reset values
`define ACC_RST 8'h00
`define IDX_RST 8'h00
`endif

// file: dest_addr_unit.v
// Destination and indirect addressing unit of an 8-bit core
// How it works
// - Indexed and immediate destination results go to RAM or register space as the reg_space_i bit selects; the other modes use RAM only.
// - Destination indexed forms the result address as operand one plus the index.
// - Destination indexed sources the accumulator and reads operand one plus index for math.
// - Destination indexed instructions are two bytes long.
// - Direct immediate writes at operand one using operand two, math reads operand one.
// - Indexed immediate writes at operand one plus index using operand two as source.
// - Both immediate destination modes are three bytes long.
// - Direct to direct copies RAM at operand two into RAM at operand one, copy only.
// - Direct to direct is three bytes long.
// - Source indirect reads a pointer at operand one and loads its target into A.
// - Destination indirect reads a pointer at operand one and stores A at its target.
// - Both indirect modes write the pointer plus one back after the access.
// - Indirect modes are accepted only for the indirect step copy.
// - Indirect instructions are two bytes long.
// - The index register is eight bits and offsets every indexed mode.
`timescale 1ns/1ps
`include "dest_addr_consts.vh"
module dest_addr_unit (
  input wire clk_i,
  input wire srst_i,
  input wire start_i,
  input wire [2:0] mode_i,
  input wire [1:0] op_i,
  input wire reg_space_i,
  input wire [7:0] oper1_i,
  input wire [7:0] oper2_i,
  input wire idx_load_i,
  input wire [7:0] idx_data_i,
  input wire [7:0] mem_rdata_i,
  output reg mem_rd_o,
  output reg mem_wr_o,
  output reg mem_reg_sel_o,
  output reg [7:0] mem_addr_o,
  output reg [7:0] mem_wdata_o,
  output reg [7:0] acc_o,
  output reg [7:0] idx_o,
  output reg [1:0] len_o,
  output reg busy_o,
  output reg done_o,
  output reg illegal_o
);
  // ==========================================
  // State and captured operands
  reg [2:0] state_r;
  reg [2:0] mode_r;
  reg [1:0] op_r;
  reg sel_r;
  reg [7:0] addr_r;
  reg [7:0] src_r;
  reg [7:0] ptr_r;
  wire [7:0] idx_sum;
  wire [8:0] idx_sum_full;
  wire [8:0] add_full;
  wire [8:0] ptr_inc_full;
  wire [7:0] ptr_inc;
  wire is_idx;
  wire legal;
  reg [7:0] alu;

  // ==========================================
  // Sequencer state codes
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RD1 = 3'h1;
  localparam [2:0] ST_RDP = 3'h3;
  localparam [2:0] ST_ACC = 3'h4;
  localparam [2:0] ST_INC = 3'h5;
  localparam [2:0] ST_DONE = 3'h6;

  // ==========================================
  // Address and data arithmetic
  // Indexed address, carry dropped so it wraps in 8 bits
  assign idx_sum_full = {1'b0, oper1_i} + {1'b0, idx_o};
  assign idx_sum = idx_sum_full[7:0];
  // Pointer plus one, carry dropped so it wraps
  assign ptr_inc_full = {1'b0, ptr_r} + 9'h001;
  assign ptr_inc = ptr_inc_full[7:0];
  // Sum for add; the carry bit is dropped and not output
  assign add_full = {1'b0, src_r} + {1'b0, mem_rdata_i};
  assign is_idx = (mode_i == `MODE_DST_IDX) || (mode_i == `MODE_DST_IDX_IMM);
  // Copy-only modes refuse other operations
  assign legal = (mode_i <= `MODE_DST_IND) &&
    (((mode_i == `MODE_DIR_DIR) || (mode_i == `MODE_SRC_IND) || (mode_i == `MODE_DST_IND))
    ? (op_i == `OP_COPY) : 1'b1);

  // Combine source with memory operand
  always @* begin
    case (op_r)
      `OP_ADD: alu = add_full[7:0];
      `OP_AND: alu = src_r & mem_rdata_i;
      `OP_OR: alu = src_r | mem_rdata_i;
      default: alu = src_r;
    endcase
  end

  // ==========================================
  // Sequencer
  always @(posedge clk_i) begin
    if (srst_i) begin
      // Every register back to its reset value
      state_r <= ST_IDLE;
      mode_r <= 3'h0;
      op_r <= `OP_COPY;
      sel_r <= 1'b0;
      addr_r <= 8'h00;
      src_r <= 8'h00;
      ptr_r <= 8'h00;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_reg_sel_o <= 1'b0;
      mem_addr_o <= 8'h00;
      mem_wdata_o <= 8'h00;
      acc_o <= `ACC_RST;
      idx_o <= `IDX_RST;
      len_o <= 2'h0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      illegal_o <= 1'b0;
    end else begin
      // Strobes last one cycle
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      done_o <= 1'b0;
      illegal_o <= 1'b0;
      // Index loads only between instructions
      if (idx_load_i && state_r == ST_IDLE) begin
        idx_o <= idx_data_i;
      end
      case (state_r)
        ST_IDLE: begin
          if (start_i) begin
            if (!legal) begin
              illegal_o <= 1'b1;
            end else begin
              mode_r <= mode_i;
              op_r <= op_i;
              busy_o <= 1'b1;
              addr_r <= is_idx ? idx_sum : oper1_i;
              // Source: A for indexed, operand two for immediates
              src_r <= (mode_i == `MODE_DST_IDX) ? acc_o : oper2_i;
              // Lengths
              if (mode_i == `MODE_DST_IDX) begin
                len_o <= `LEN_TWO;
              end else if (mode_i == `MODE_DST_DIR_IMM || mode_i == `MODE_DST_IDX_IMM) begin
                len_o <= `LEN_THREE;
              end else if (mode_i == `MODE_DIR_DIR) begin
                len_o <= `LEN_THREE;
              end else begin
                len_o <= `LEN_TWO;
              end
              // First read: source byte, destination byte or pointer
              mem_rd_o <= 1'b1;
              if (mode_i == `MODE_DIR_DIR) begin
                sel_r <= 1'b0;
                mem_reg_sel_o <= 1'b0;
                mem_addr_o <= oper2_i;
                state_r <= ST_RD1;
              end else if (mode_i == `MODE_SRC_IND || mode_i == `MODE_DST_IND) begin
                sel_r <= 1'b0;
                mem_reg_sel_o <= 1'b0;
                mem_addr_o <= oper1_i;
                state_r <= ST_RDP;
              end else begin
                sel_r <= reg_space_i;
                mem_reg_sel_o <= reg_space_i;
                mem_addr_o <= is_idx ? idx_sum : oper1_i;
                state_r <= ST_RD1;
              end
            end
          end
        end
        ST_RD1: begin
          // Read data valid now; write result
          mem_wr_o <= 1'b1;
          mem_reg_sel_o <= sel_r;
          mem_addr_o <= addr_r;
          if (mode_r == `MODE_DIR_DIR) begin
            mem_wdata_o <= mem_rdata_i;
          end else begin
            mem_wdata_o <= alu;
          end
          state_r <= ST_DONE;
        end
        ST_RDP: begin
          // Pointer arrived; access its target
          ptr_r <= mem_rdata_i;
          mem_addr_o <= mem_rdata_i;
          if (mode_r == `MODE_SRC_IND) begin
            mem_rd_o <= 1'b1;
            state_r <= ST_ACC;
          end else begin
            mem_wr_o <= 1'b1;
            mem_wdata_o <= acc_o;
            state_r <= ST_INC;
          end
        end
        ST_ACC: begin
          // Target byte arrives; load accumulator
          acc_o <= mem_rdata_i;
          state_r <= ST_INC;
        end
        ST_INC: begin
          // Write back incremented pointer
          mem_wr_o <= 1'b1;
          mem_addr_o <= addr_r;
          mem_wdata_o <= ptr_inc;
          state_r <= ST_DONE;
        end
        ST_DONE: begin
          // Report completion and return to idle
          busy_o <= 1'b0;
          done_o <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: begin
          // Unused codes fall back to idle
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// file: mem_model.sv
// Behavioural RAM and register space beside the addressing unit
`timescale 1ns/1ps
module mem_model (
  input wire clk_i, rd_i, wr_i, sel_i,
  input wire [7:0] addr_i, wdata_i,
  output wire [7:0] rdata_o
);
  logic [7:0] ram [256];
  logic [7:0] regs [256];
  logic rd_q = 1'b0;
  // Known pattern in both spaces
  initial for (int i = 0; i < 256; i++) begin
    ram[i] = 8'(i) ^ 8'hA5;
    regs[i] = 8'(i) ^ 8'h5A;
  end
  // Data valid only around a read, scrambled otherwise
  assign rdata_o = (sel_i ? regs[addr_i] : ram[addr_i]) ^ ((rd_i | rd_q) ? 8'h00 : 8'hFF);
  // Write into the selected space
  always @(posedge clk_i) begin
    rd_q <= rd_i;
    if (wr_i && sel_i) regs[addr_i] <= wdata_i;
    else if (wr_i) ram[addr_i] <= wdata_i;
  end
endmodule

// file: dest_addr_monitor.sv
// Checker for the addressing unit ports
`timescale 1ns/1ps
module dest_addr_monitor (
  input wire clk_i, srst_i, start_i, reg_space_i, idx_load_i,
  input wire [2:0] mode_i,
  input wire [1:0] op_i,
  input wire [7:0] oper1_i, oper2_i, idx_data_i, mem_rdata_i,
  input wire mem_rd_o, mem_wr_o, mem_reg_sel_o, busy_o, done_o, illegal_o,
  input wire [7:0] mem_addr_o, mem_wdata_o, acc_o, idx_o,
  input wire [1:0] len_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Request taken while idle
  wire tk = start_i && !busy_o;
  // =====================================
  // Properties
  property p_len2; tk && (mode_i == 3'h0 || (mode_i > 3'h3 && mode_i < 3'h6 && op_i == 2'h0))
    |=> len_o == 2'h2; endproperty
  a_len2: assert property (p_len2) else $error("len two");
  property p_len3; tk && (mode_i == 3'h1 || mode_i == 3'h2 || (mode_i == 3'h3 && op_i == 2'h0))
    |=> len_o == 2'h3; endproperty
  a_len3: assert property (p_len3) else $error("len three");
  property p_idx; tk && mode_i == 3'h0 && op_i != 2'h0
    |=> mem_rd_o && mem_addr_o == 8'($past(oper1_i) + $past(idx_o)); endproperty
  a_idx: assert property (p_idx) else $error("indexed addr");
  property p_dimm; tk && mode_i == 3'h1 && op_i != 2'h0 |=> mem_rd_o &&
    mem_addr_o == $past(oper1_i) ##1 mem_wr_o && mem_addr_o == $past(oper1_i, 2); endproperty
  a_dimm: assert property (p_dimm) else $error("direct imm");
  property p_space; tk && mode_i < 3'h3 |=> ##1 mem_reg_sel_o == $past(reg_space_i, 2); endproperty
  a_space: assert property (p_space) else $error("space");
  property p_dd; tk && mode_i == 3'h3 && op_i == 2'h0 |=> mem_rd_o && !mem_reg_sel_o &&
    mem_addr_o == $past(oper2_i) ##1 mem_wr_o && mem_addr_o == $past(oper1_i, 2); endproperty
  a_dd: assert property (p_dd) else $error("direct copy");
  property p_ref; tk && mode_i > 3'h2 && op_i != 2'h0 |=> illegal_o && !mem_rd_o && !mem_wr_o;
  endproperty
  a_ref: assert property (p_ref) else $error("refusal");
  property p_dind; tk && mode_i == 3'h5 && op_i == 2'h0 |=> mem_rd_o ##1 mem_wr_o &&
    mem_wdata_o == acc_o ##1 mem_wr_o && mem_addr_o == $past(oper1_i, 3); endproperty
  a_dind: assert property (p_dind) else $error("dst indirect");
  property p_sind; tk && mode_i == 3'h4 && op_i == 2'h0 |=> mem_rd_o ##1 mem_rd_o ##2
    mem_wr_o && mem_addr_o == $past(oper1_i, 4) ##1 done_o; endproperty
  a_sind: assert property (p_sind) else $error("src indirect");
  property p_acc; tk && mode_i != 3'h4 && mode_i < 3'h6 && (mode_i < 3'h3 || op_i == 2'h0)
    |=> $stable(acc_o)[*4]; endproperty
  a_acc: assert property (p_acc) else $error("acc changed");
  property p_busy; tk && mode_i < 3'h3 |=> busy_o ##2 done_o && !busy_o; endproperty
  a_busy: assert property (p_busy) else $error("busy or done");
endmodule
bind dest_addr_unit dest_addr_monitor u_dest_addr_monitor (.*);

// file: cpu_dest_indirect_addressing_test.sv
// Self-checking bench for the addressing unit
`timescale 1ns/1ps
module cpu_dest_indirect_addressing_test;
  logic clk_i = 0, srst_i = 1, start_i = 0, reg_space_i = 0, idx_load_i = 0;
  logic [2:0] mode_i = 0;
  logic [1:0] op_i = 0;
  logic [7:0] oper1_i = 0, oper2_i = 0, idx_data_i = 0, wa, wd;
  wire [7:0] mem_rdata_i, mem_addr_o, mem_wdata_o, acc_o, idx_o;
  wire mem_rd_o, mem_wr_o, mem_reg_sel_o, busy_o, done_o, illegal_o;
  wire [1:0] len_o;
  int miscompares = 0, n_tests = 0, cyc = 0, nw = 0, k;
  // Rows: mode, op, space, oper1, oper2, len, write addr, write data, acc
  logic [47:0] rows [8] = '{{3'h0, 3'h2, 16'h1000, 2'h2, 24'h08AD00},
    {3'h1, 3'h3, 16'h2003, 2'h3, 24'h207D00}, {3'h2, 3'h6, 16'h300F, 2'h3, 24'h288F00},
    {3'h3, 3'h0, 16'h4041, 2'h3, 24'h40E400}, {3'h4, 3'h0, 16'h5000, 2'h2, 24'h50F650},
    {3'h5, 3'h0, 16'h6000, 2'h2, 24'h60C650}, {3'h0, 3'h1, 16'h0900, 2'h2, 24'h015050},
    {3'h2, 3'h5, 16'h0AFF, 2'h3, 24'h025850}};
  always #2.5 clk_i = ~clk_i;
  dest_addr_unit u_dest_addr_unit (.*);
  mem_model u_mem_model (.clk_i(clk_i), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
    .sel_i(mem_reg_sel_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
  // Record writes and cut a hang short
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (mem_wr_o === 1'b1) begin
      wa <= mem_addr_o;
      wd <= mem_wdata_o;
      nw <= nw + 1;
    end
    if (cyc == 3000) begin
      miscompares++;
      print_verdict;
    end
  end
  task print_verdict;
    if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // Issue one request and wait for its end
  task run(input logic [21:0] c);
    @(posedge clk_i);
    #1 {mode_i, op_i, reg_space_i, oper1_i, oper2_i} = c;
    start_i = 1;
    @(posedge clk_i);
    #1 start_i = 0;
    repeat (8) begin
      if (done_o !== 1'b1 && illegal_o !== 1'b1) begin
        @(posedge clk_i);
        #1;
      end
    end
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    #1 srst_i = 0;
    chk("acc", 8'h00, acc_o);
    chk("len", 8'h00, {6'h0, len_o});
    idx_load_i = 1;
    idx_data_i = 8'hF8;
    @(posedge clk_i);
    #1 idx_load_i = 0;
    chk("idx", 8'hF8, idx_o);
    for (int i = 0; i < 8; i++) begin
      run(rows[i][47:26]);
      chk("len", {6'h0, rows[i][25:24]}, {6'h0, len_o});
      chk("addr", rows[i][23:16], wa);
      chk("data", rows[i][15:8], wd);
      chk("acc", rows[i][7:0], acc_o);
    end
    k = nw;
    run({3'h3, 3'h2, 16'h4142});
    chk("illegal", 8'h01, {7'h0, illegal_o});
    run({3'h4, 3'h6, 16'h5000});
    chk("illegal", 8'h01, {7'h0, illegal_o});
    chk("writes", 8'(k), 8'(nw));
    // Index load ignored while busy, then a reset in mid-instruction
    @(posedge clk_i);
    #1 {mode_i, op_i, reg_space_i, oper1_i, oper2_i} = {3'h4, 3'h0, 16'h5000};
    start_i = 1;
    @(posedge clk_i);
    #1 start_i = 0;
    idx_load_i = 1;
    idx_data_i = 8'h33;
    @(posedge clk_i);
    #1 idx_load_i = 0;
    chk("idx", 8'hF8, idx_o);
    chk("busy", 8'h01, {7'h0, busy_o});
    srst_i = 1;
    @(posedge clk_i);
    #1 srst_i = 0;
    chk("busy", 8'h00, {7'h0, busy_o});
    chk("acc", 8'h00, acc_o);
    chk("idx", 8'h00, idx_o);
    run({3'h1, 3'h1, 16'h7005});
    chk("addr", 8'h70, wa);
    chk("data", 8'h05, wd);
    chk("len", 8'h03, {6'h0, len_o});
    print_verdict;
  end
endmodule
